//--- rtl/serial_port_consts.svh
// Offsets, field positions, reset values and codes of the serial port registers.
// Assumes inclusion by bare name from the package only; the design module sees its macros through it.
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
// Word byte addresses on the register bus
`define OFF_STATUS 4'h0
`define OFF_CTRL_ONE 4'h4
`define OFF_CTRL_TWO 4'h8
`define OFF_DATA_BUF 4'hc
// Shared slave address and mask slot, and the interrupt event register
`define OFF_SLAVE_ADDR 5'h10
`define OFF_EVENT 5'h14
// Status bit positions
`define ST_SLEW 7
`define ST_SMBUS 6
`define ST_DATA_ADDR 5
`define ST_STOP 4
`define ST_START 3
`define ST_RW 2
`define ST_UPDATE 1
`define ST_FULL 0
// Control register two bit positions
`define C2_GENERAL_CALL_ENABLE 7
`define C2_ACK_STATUS 6
`define C2_ACK_DATA_VALUE 5
`define C2_ACK_SEQUENCE_ENABLE 4
`define C2_RECEIVE_ENABLE 3
`define C2_PEN 2
`define C2_REPEATED_START_ENABLE 1
`define C2_SEN 0
// Mode codes
`define MODE_SLAVE7 4'h6
`define MODE_SLAVE10 4'h7
`define MODE_MASTER 4'h8
`define MODE_MASK_ACCESS 4'h9
`define MODE_FW_MASTER 4'hb
`define MODE_SLAVE7_SP 4'he
`define MODE_SLAVE10_SP 4'hf
// Reset values
`define RST_MASK 8'hff
`define RST_ZERO 8'h00
// Unmapped read answer
`define UNMAPPED_DATA 32'h0000_0000
`endif

//--- rtl/serial_port_pkg.sv
// Types for the serial port register block.
// Assumes the constants header is on the include path.
package serial_port_pkg;
    `include "serial_port_consts.svh"
    typedef logic [7:0] byte_type;
    typedef enum logic [1:0] {
        role_off,
        role_slave,
        role_master
    } role_type;
endpackage : serial_port_pkg

//--- rtl/serial_port_regs.sv
// Control and status registers of a two-wire serial port, master and slave.
// Assumes a shift engine outside that reports bus events as one-cycle pulses.
//------------------------------------------------------------
// What this block does
// R1: Bus-input select picks SMBus input thresholds
// R2: Slave data-or-address flag tracks last byte
// R3: Stop/start flags show the last condition
// R4: Reset or disable clears stop/start flags
// R5: Direction flag: slave address bit, master transmit
// R6: Active is OR of direction and sequence bits
// R7: Ten-bit slave sets address update flag
// R8: Buffer full set while buffer holds byte
// R9: Write collision is sticky, software clears it
// R10: Receive overflow sticky when byte arrives full
// R11: Port enable hands pins to serial port
// R12: Slave clock release bit stretches clock low
// R13: Mode field selects slave and firmware modes
// R14: Mode 1000 master clock from address value
// R15: Mode 1001 redirects address slot to mask
// R16: General call enable gates general call interrupt
// R17: Acknowledge status reports slave's returned bit
// R18: Acknowledge enable sends ack data, self-clears
// R19: Receive enable puts master into receive
// R20: Start/restart/stop bits trigger conditions, self-clear
// R21: Active refuses new sequence bits, buffer writes
// R22: Mask field makes slave-address bits don't-care
// R23: Control two bit 0 enables slave stretching
// R24: Matched address loads buffer, acks, interrupts
// R25: Control two layout follows master or slave
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module serial_port_regs
    import serial_port_pkg::*;
#(
    parameter int CLK_MHZ = 100
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic ev_start,
    input wire logic ev_stop,
    input wire logic ev_nack,
    input wire logic ev_byte_done,
    input wire logic ev_byte_is_data,
    input wire logic [7:0] ev_rx_byte,
    input wire logic ev_tx_busy,
    input wire logic ev_bus_idle,
    input wire logic ev_ack_in,
    input wire logic ev_seq_done,
    output logic pins_to_port,
    output logic smbus_inputs,
    output logic slew_control,
    output logic scl_stretch,
    output logic stretch_enable,
    output logic [7:0] eff_address_mask,
    output logic [7:0] slave_address_out,
    output logic [7:0] data_buffer_out,
    output logic tx_load,
    output logic ack_out_value,
    output logic [4:0] master_cmd,
    output logic master_clk_en,
    output logic port_interrupt_flag,
    output logic module_active
);
    // Registers, bus write and read strobes, and flags
    logic [7:0] status_ff, ctrl_one_ff, ctrl_two_ff, data_buffer_ff;
    logic [7:0] slave_address_reg_ff, address_mask_reg_ff;
    logic [31:0] nxt_readdata;
    logic [7:0] wbyte;
    logic wr_stat, wr_c1, wr_c2, wr_buf, wr_addr, rd_buf, wr_event;
    logic full_ff, ovf_ff, write_collision_flag_ff, irq_ff, rw_ff, da_ff, ua_ff;
    logic start_seen_ff, stop_seen_ff, ack_status_ff;
    logic [7:0] baud_cnt_ff;
    logic is_master, is_slave, is_ten_bit, mask_access, active;
    role_type role;
    logic buf_accept;

    // Mode decode used by several processes
    function automatic role_type decode_role(input logic [3:0] m, input logic en);
        if (!en)
            decode_role = role_off;
        else if (m == `MODE_MASTER || m == `MODE_FW_MASTER)
            decode_role = role_master;
        else if (m == `MODE_SLAVE7 || m == `MODE_SLAVE10 || m == `MODE_SLAVE7_SP
            || m == `MODE_SLAVE10_SP || m == `MODE_MASK_ACCESS)
            decode_role = role_slave;
        else
            decode_role = role_off;
    endfunction : decode_role

    assign role = decode_role(ctrl_one_ff[3:0], ctrl_one_ff[5]); // R13
    assign is_master = (role == role_master);
    assign is_slave = (role == role_slave);
    assign is_ten_bit = ctrl_one_ff[3:0] == `MODE_SLAVE10
        || ctrl_one_ff[3:0] == `MODE_SLAVE10_SP;
    assign mask_access = ctrl_one_ff[3:0] == `MODE_MASK_ACCESS; // R15
    assign active = rw_ff | (|ctrl_two_ff[4:0] & is_master); // R6
    assign module_active = active;

    //------------------------------------------------------------
    // Register bus decode
    //------------------------------------------------------------
    assign avs_waitrequest = 1'b0;
    assign wbyte = avs_writedata[7:0];
    assign wr_stat = avs_write && avs_byteenable[0] && avs_address == 5'(`OFF_STATUS);
    assign wr_c1 = avs_write && avs_byteenable[0] && avs_address == 5'(`OFF_CTRL_ONE);
    assign wr_c2 = avs_write && avs_byteenable[0] && avs_address == 5'(`OFF_CTRL_TWO);
    assign wr_buf = avs_write && avs_byteenable[0] && avs_address == 5'(`OFF_DATA_BUF);
    assign wr_addr = avs_write && avs_byteenable[0] && avs_address == `OFF_SLAVE_ADDR;
    assign wr_event = avs_write && avs_byteenable[0] && avs_address == `OFF_EVENT;
    assign rd_buf = avs_read && avs_address == 5'(`OFF_DATA_BUF);

    // Read mux, combinational, drives read data directly
    always_comb begin
        nxt_readdata = `UNMAPPED_DATA;
        case (avs_address)
            5'(`OFF_STATUS): nxt_readdata = {24'h0, status_ff[7:6], da_ff & is_slave,
                stop_seen_ff, start_seen_ff, rw_ff, ua_ff, full_ff}; // R2 R8
            5'(`OFF_CTRL_ONE): nxt_readdata = {24'h0, write_collision_flag_ff, ovf_ff, ctrl_one_ff[5:0]};
            5'(`OFF_CTRL_TWO): nxt_readdata = {24'h0, ctrl_two_ff[7], ack_status_ff,
                ctrl_two_ff[5:0]};
            5'(`OFF_DATA_BUF): nxt_readdata = {24'h0, data_buffer_ff};
            `OFF_SLAVE_ADDR: nxt_readdata = {24'h0, mask_access ? address_mask_reg_ff
                : slave_address_reg_ff}; // R15
            `OFF_EVENT: nxt_readdata = {31'h0, irq_ff};
            default: nxt_readdata = `UNMAPPED_DATA;
        endcase
    end
    assign avs_readdata = nxt_readdata;

    //------------------------------------------------------------
    // Control registers
    //------------------------------------------------------------
    // Status upper bits and control one
    always_ff @(posedge clk) begin
        if (rst) begin
            status_ff <= `RST_ZERO;
            ctrl_one_ff <= `RST_ZERO;
        end else begin
            if (wr_stat)
                status_ff <= {wbyte[7:6], 6'h0}; // R1
            if (wr_c1)
                ctrl_one_ff <= {2'b00, wbyte[5:0]}; // R11 R12 R13
        end
    end

    // Control two: sequence bits refused while active, self-clear on done
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_two_ff <= `RST_ZERO;
        end else if (wr_c2) begin
            if (is_master && active)
                ctrl_two_ff <= {wbyte[7:5], ctrl_two_ff[4:0]}; // R21
            else
                ctrl_two_ff <= wbyte; // R25
        end else if (is_master && ev_seq_done) begin
            ctrl_two_ff[4:0] <= 5'h0; // R18 R19 R20
        end
    end

    // Address and mask registers sharing one slot
    always_ff @(posedge clk) begin
        if (rst) begin
            slave_address_reg_ff <= `RST_ZERO;
            address_mask_reg_ff <= `RST_MASK;
        end else if (wr_addr) begin
            if (mask_access)
                address_mask_reg_ff <= wbyte; // R15
            else
                slave_address_reg_ff <= wbyte;
        end
    end

    // Data buffer and its full flag
    always_ff @(posedge clk) begin
        if (rst) begin
            data_buffer_ff <= `RST_ZERO;
            full_ff <= 1'b0;
        end else if (ev_byte_done && is_slave && !full_ff && !ovf_ff) begin
            data_buffer_ff <= ev_rx_byte; // R24
            full_ff <= 1'b1; // R8
        end else if (wr_buf && buf_accept) begin
            data_buffer_ff <= wbyte;
            full_ff <= 1'b1;
        end else if (rd_buf || (ev_byte_done && !is_slave)) begin
            full_ff <= 1'b0;
        end
    end
    // A buffer write is refused while a master sequence runs or the bus is
    // taken, and while a slave byte is still going out; refusal flags collision
    assign buf_accept = !(is_master && (active || !ev_bus_idle))
        && !(is_slave && ev_tx_busy); // R21
    assign tx_load = wr_buf && buf_accept; // R21

    // Sticky collision and overflow; set wins over software clear
    always_ff @(posedge clk) begin
        if (rst) begin
            write_collision_flag_ff <= 1'b0;
            ovf_ff <= 1'b0;
        end else begin
            if (wr_buf && ((is_master && (active || !ev_bus_idle))
                || (is_slave && ev_tx_busy)))
                write_collision_flag_ff <= 1'b1; // R9
            else if (wr_c1 && !wbyte[7])
                write_collision_flag_ff <= 1'b0;
            if (ev_byte_done && full_ff)
                ovf_ff <= 1'b1; // R10
            else if (wr_c1 && !wbyte[6])
                ovf_ff <= 1'b0;
        end
    end

    // Start and stop seen flags
    always_ff @(posedge clk) begin
        if (rst || !ctrl_one_ff[5]) begin
            start_seen_ff <= 1'b0; // R4
            stop_seen_ff <= 1'b0;
        end else if (ev_start) begin
            start_seen_ff <= 1'b1; // R3
            stop_seen_ff <= 1'b0;
        end else if (ev_stop) begin
            start_seen_ff <= 1'b0;
            stop_seen_ff <= 1'b1;
        end
    end

    // Direction, data-or-address, update and acknowledge status
    always_ff @(posedge clk) begin
        if (rst) begin
            rw_ff <= 1'b0;
            da_ff <= 1'b0;
            ua_ff <= 1'b0;
            ack_status_ff <= 1'b0;
        end else begin
            if (is_master)
                rw_ff <= ev_tx_busy; // R5
            else if (ev_start || ev_stop || ev_nack)
                rw_ff <= 1'b0;
            else if (ev_byte_done && !ev_byte_is_data)
                rw_ff <= ev_rx_byte[0];
            if (ev_byte_done)
                da_ff <= ev_byte_is_data; // R2
            if (is_slave && is_ten_bit && ev_byte_done && !ev_byte_is_data)
                ua_ff <= 1'b1; // R7
            else if (wr_addr)
                ua_ff <= 1'b0;
            if (is_master && ev_byte_done)
                ack_status_ff <= ev_ack_in; // R17
        end
    end

    // Interrupt flag: byte events, general call gated, software clears
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_ff <= 1'b0;
        end else if (ev_byte_done && (ev_rx_byte != 8'h00 || ctrl_two_ff[7]
            || !is_slave)) begin
            irq_ff <= 1'b1; // R16 R24
        end else if (wr_event && wbyte[0]) begin
            irq_ff <= 1'b0;
        end
    end

    // Baud enable: period of 2 * (address[6:0] + 1) system cycles
    always_ff @(posedge clk) begin
        if (rst || ctrl_one_ff[3:0] != `MODE_MASTER)
            baud_cnt_ff <= 8'h00;
        else if (baud_cnt_ff == 8'({slave_address_reg_ff[6:0], 1'b0} + 8'h1))
            baud_cnt_ff <= 8'h00; // R14
        else
            baud_cnt_ff <= baud_cnt_ff + 8'h1;
    end
    assign master_clk_en = (ctrl_one_ff[3:0] == `MODE_MASTER)
        && baud_cnt_ff == 8'({slave_address_reg_ff[6:0], 1'b0} + 8'h1);

    //------------------------------------------------------------
    // Outputs to the pin and shift logic
    //------------------------------------------------------------
    assign pins_to_port = ctrl_one_ff[5]; // R11
    assign smbus_inputs = status_ff[`ST_SMBUS]; // R1
    assign slew_control = status_ff[`ST_SLEW];
    assign scl_stretch = is_slave && !ctrl_one_ff[4]; // R12
    assign stretch_enable = is_slave && ctrl_two_ff[0]; // R23
    assign eff_address_mask = mask_access ? address_mask_reg_ff
        : {2'b00, ctrl_two_ff[5:2], ctrl_two_ff[1], ctrl_two_ff[1] & is_ten_bit}; // R22
    assign slave_address_out = slave_address_reg_ff;
    assign data_buffer_out = data_buffer_ff;
    assign ack_out_value = ctrl_two_ff[5]; // R18
    assign master_cmd = is_master ? ctrl_two_ff[4:0] : 5'h0; // R19 R20
    assign port_interrupt_flag = irq_ff;

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    // A slave byte taken while the buffer and overflow are clear
    sequence slave_byte_in;
        is_slave && ev_byte_done && !full_ff && !ovf_ff;
    endsequence
    // A sequence finishing with no control two write in the same cycle
    sequence seq_finish;
        is_master && ev_seq_done && !wr_c2;
    endsequence

    // Start and stop flags
    chk_flags_cleared: assert property (@(posedge clk) disable iff (rst) // R4
        !ctrl_one_ff[5] |=> !start_seen_ff && !stop_seen_ff) else $error("flags kept");
    chk_stop_last: assert property (@(posedge clk) disable iff (rst) // R3
        ctrl_one_ff[5] && ev_stop && !ev_start |=> stop_seen_ff) else $error("stop lost");
    chk_start_last: assert property (@(posedge clk) disable iff (rst) // R3
        ctrl_one_ff[5] && ev_start |=> start_seen_ff && !stop_seen_ff)
        else $error("start lost");

    // Sticky error flags
    chk_ovf_sticky: assert property (@(posedge clk) disable iff (rst) // R10
        ev_byte_done && full_ff |=> ovf_ff) else $error("overflow lost");
    chk_write_collision_flag_set: assert property (@(posedge clk) disable iff (rst) // R9
        wr_buf && is_slave && ev_tx_busy |=> write_collision_flag_ff) else $error("collision lost");
    chk_write_collision_flag_master: assert property (@(posedge clk) disable iff (rst) // R9
        wr_buf && is_master && !ev_bus_idle |=> write_collision_flag_ff) else $error("master collision lost");

    // Slave receive path, its flags and clock stretch
    chk_buffer_load: assert property (@(posedge clk) disable iff (rst) // R24
        slave_byte_in |=> full_ff && data_buffer_ff == $past(ev_rx_byte))
        else $error("byte not loaded");
    chk_ua_set: assert property (@(posedge clk) disable iff (rst) // R7
        is_slave && is_ten_bit && ev_byte_done && !ev_byte_is_data |=> ua_ff)
        else $error("update flag lost");
    chk_gcall_ignored: assert property (@(posedge clk) disable iff (rst) // R16
        is_slave && !ctrl_two_ff[7] && ev_byte_done && ev_rx_byte == 8'h00 && !irq_ff
        |=> !irq_ff) else $error("general call taken");
    chk_stretch_out: assert property (@(posedge clk) disable iff (rst) // R12
        wr_c1 && !wbyte[4] && decode_role(wbyte[3:0], wbyte[5]) == role_slave
        |=> scl_stretch) else $error("no stretch");

    // Master sequence bits and bit rate
    chk_active_or: assert property (@(posedge clk) disable iff (rst) // R6
        is_master && wr_c2 && !active && wbyte[0] |=> module_active) else $error("not active");
    chk_no_spool: assert property (@(posedge clk) disable iff (rst) // R21
        is_master && active && wr_c2 && !ev_seq_done
        |=> ctrl_two_ff[4:0] == $past(ctrl_two_ff[4:0])) else $error("spool");
    chk_seq_clear: assert property (@(posedge clk) disable iff (rst) // R20
        seq_finish |=> ctrl_two_ff[4:0] == 5'h0) else $error("not cleared");
    chk_ack_status: assert property (@(posedge clk) disable iff (rst) // R17
        is_master && ev_byte_done |=> ack_status_ff == $past(ev_ack_in))
        else $error("ack status lost");
    chk_baud_gap: assert property (@(posedge clk) disable iff (rst) // R14
        master_clk_en |=> !master_clk_en) else $error("baud pulse too long");
endmodule : serial_port_regs
`default_nettype wire

//--- test/bus_event_model.sv
// Stand-in for the shift engine and the far side of the bus: emits event pulses.
// Assumes the bench raises go for one cycle with the kind, delay and byte to send.
`timescale 1ns/1ns
`default_nettype none
module bus_event_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic [1:0] kind,
    input wire logic [3:0] lat,
    input wire logic [7:0] rx_in,
    input wire logic is_data,
    input wire logic busy,
    output logic ev_start,
    output logic ev_stop,
    output logic ev_byte_done,
    output logic ev_seq_done,
    output logic ev_byte_is_data,
    output logic [7:0] ev_rx_byte,
    output logic ev_tx_busy
);
    logic pend_ff;
    logic [3:0] wait_ff;
    logic [1:0] kind_ff;
    logic [7:0] rx_ff;
    logic fire;
    // Hold the request for a prompt or slow answer
    always_ff @(posedge clk) begin
        if (rst) begin
            pend_ff <= 1'b0;
        end else if (go) begin
            pend_ff <= 1'b1;
            wait_ff <= lat;
            kind_ff <= kind;
            rx_ff <= rx_in;
        end else if (pend_ff) begin
            wait_ff <= wait_ff - 4'h1;
            pend_ff <= (wait_ff != 4'h0);
        end
    end
    // One-cycle event pulses; the byte is only meaningful with its pulse
    assign fire = pend_ff && (wait_ff == 4'h0);
    assign ev_start = fire && (kind_ff == 2'h0);
    assign ev_stop = fire && (kind_ff == 2'h1);
    assign ev_byte_done = fire && (kind_ff == 2'h2);
    assign ev_seq_done = fire && (kind_ff == 2'h3);
    assign ev_rx_byte = ev_byte_done ? rx_ff : ~rx_ff;
    assign ev_byte_is_data = is_data;
    assign ev_tx_busy = busy;
endmodule : bus_event_model
`default_nettype wire

//--- test/tb_serial_port_regs.sv
// Self-checking bench for the serial port register block.
// Assumes the design package and the event model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module tb_serial_port_regs;
    import serial_port_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic go = 1'b0, is_data = 1'b0, busy = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [3:0] lat = 4'h1;
    logic [7:0] rx_in = 8'h00;
    logic nack = 1'b0, idle = 1'b1, ack_in = 1'b0;
    logic [7:0] eff_address_mask, slave_address_out, data_buffer_out;
    logic [4:0] master_cmd;
    logic ev_start, ev_stop, ev_byte_done, ev_seq_done, ev_byte_is_data, ev_tx_busy;
    logic [7:0] ev_rx_byte;
    logic pins_to_port, smbus_inputs, slew_control, scl_stretch, stretch_enable;
    logic tx_load, ack_out_value, master_clk_en, port_interrupt_flag, module_active;
    int failures = 0;
    int samples_checked = 0;
    int loads = 0;
    int n;
    logic [31:0] rdv;
    // Clock at 100 MHz
    always #5 clk = ~clk;
    // Count accepted buffer loads
    always @(posedge clk) if (tx_load === 1'b1) loads++;
    bus_event_model far (.clk(clk), .rst(rst), .go(go), .kind(kind), .lat(lat),
        .rx_in(rx_in), .is_data(is_data), .busy(busy), .ev_start(ev_start),
        .ev_stop(ev_stop), .ev_byte_done(ev_byte_done), .ev_seq_done(ev_seq_done),
        .ev_byte_is_data(ev_byte_is_data), .ev_rx_byte(ev_rx_byte), .ev_tx_busy(ev_tx_busy));
    serial_port_regs dut (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ev_start(ev_start), .ev_stop(ev_stop),
        .ev_nack(nack), .ev_byte_done(ev_byte_done), .ev_byte_is_data(ev_byte_is_data),
        .ev_rx_byte(ev_rx_byte), .ev_tx_busy(ev_tx_busy), .ev_bus_idle(idle),
        .ev_ack_in(ack_in), .ev_seq_done(ev_seq_done), .pins_to_port(pins_to_port),
        .smbus_inputs(smbus_inputs), .slew_control(slew_control), .scl_stretch(scl_stretch),
        .stretch_enable(stretch_enable), .eff_address_mask(eff_address_mask),
        .slave_address_out(slave_address_out), .data_buffer_out(data_buffer_out),
        .tx_load(tx_load), .ack_out_value(ack_out_value),
        .master_cmd(master_cmd), .master_clk_en(master_clk_en),
        .port_interrupt_flag(port_interrupt_flag), .module_active(module_active));
    // Verdict and end of run
    task end_sim;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // Compare a seen value with the expected one
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask : chk
    // One Avalon transfer, held until waitrequest is sampled low
    task acc(input logic w, input logic [4:0] a, input logic [31:0] wd);
        int i;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= wd;
        if (w) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (i == 20) begin
            failures++;
            end_sim;
        end
    endtask : acc
    task wr(input logic [4:0] a, input logic [7:0] d);
        acc(1'b1, a, {24'h0, d});
    endtask : wr
    // Read and compare the bits selected by the mask
    task rdchk(input logic [4:0] a, input logic [7:0] exp, input logic [7:0] m);
        acc(1'b0, a, 32'h0);
        chk(rdv & {24'h0, m}, {24'h0, exp & m});
    endtask : rdchk
    // Ask the far side for an event and let it land
    task ev(input logic [1:0] k, input logic [7:0] b, input logic d);
        @(posedge clk);
        go <= 1'b1;
        kind <= k;
        rx_in <= b;
        is_data <= d;
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
    endtask : ev
    // Cycles between two master clock enable pulses
    task period;
        n = 1;
        for (int i = 0; i < 60 && master_clk_en !== 1'b1; i++) @(negedge clk);
        @(negedge clk);
        while (master_clk_en !== 1'b1 && n < 60) begin
            n++;
            @(negedge clk);
        end
    endtask : period
    // Cut a hang short
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        end_sim;
    end
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rdchk(5'h00, 8'h00, 8'hff);
        rdchk(5'h04, 8'h00, 8'hff);
        rdchk(5'h08, 8'h00, 8'hff);
        rdchk(5'h18, 8'h00, 8'hff);
        wr(5'h04, 8'h09);
        rdchk(5'h10, 8'hff, 8'hff);
        wr(5'h10, 8'h5a);
        rdchk(5'h10, 8'h5a, 8'hff);
        wr(5'h04, 8'h06);
        rdchk(5'h10, 8'h00, 8'hff);
        wr(5'h00, 8'hc0);
        @(negedge clk);
        chk(smbus_inputs, 1);
        chk(slew_control, 1);
        $display("test reset_and_slot done");
        lat = 4'h1;
        wr(5'h04, 8'h36);
        @(negedge clk);
        chk(pins_to_port, 1);
        chk(scl_stretch, 0);
        ev(2'h0, 8'h00, 1'b0);
        rdchk(5'h00, 8'h08, 8'h18);
        ev(2'h2, 8'h42, 1'b0);
        rdchk(5'h00, 8'hc9, 8'hff);
        rdchk(5'h14, 8'h01, 8'h01);
        rdchk(5'h0c, 8'h42, 8'hff);
        rdchk(5'h00, 8'h00, 8'h01);
        ev(2'h2, 8'h43, 1'b0);
        rdchk(5'h00, 8'h05, 8'h25);
        chk(data_buffer_out, 8'h43);
        rdchk(5'h0c, 8'h43, 8'hff);
        nack <= 1'b1;
        @(posedge clk);
        nack <= 1'b0;
        rdchk(5'h00, 8'h00, 8'h04);
        wr(5'h14, 8'h01);
        ev(2'h2, 8'h00, 1'b0);
        rdchk(5'h14, 8'h00, 8'h01);
        rdchk(5'h0c, 8'h00, 8'hff);
        wr(5'h08, 8'h80);
        ev(2'h2, 8'h00, 1'b0);
        rdchk(5'h14, 8'h01, 8'h01);
        rdchk(5'h0c, 8'h00, 8'hff);
        wr(5'h08, 8'h00);
        lat = 4'h9;
        ev(2'h2, 8'ha5, 1'b1);
        rdchk(5'h00, 8'h21, 8'h21);
        ev(2'h2, 8'h3c, 1'b1);
        rdchk(5'h04, 8'h76, 8'hff);
        rdchk(5'h0c, 8'ha5, 8'hff);
        wr(5'h04, 8'h36);
        rdchk(5'h04, 8'h36, 8'hff);
        ev(2'h1, 8'h00, 1'b0);
        rdchk(5'h00, 8'h10, 8'h18);
        busy <= 1'b1;
        wr(5'h0c, 8'h11);
        rdchk(5'h04, 8'hb6, 8'hff);
        busy <= 1'b0;
        wr(5'h08, 8'h3e);
        @(negedge clk);
        chk(eff_address_mask, 8'h3e);
        wr(5'h04, 8'h27);
        @(negedge clk);
        chk(eff_address_mask, 8'h3f);
        ev(2'h2, 8'hf0, 1'b0);
        rdchk(5'h00, 8'h02, 8'h02);
        wr(5'h10, 8'h02);
        rdchk(5'h00, 8'h00, 8'h02);
        rdchk(5'h0c, 8'hf0, 8'hff);
        wr(5'h04, 8'h26);
        wr(5'h08, 8'h01);
        @(negedge clk);
        chk(scl_stretch, 1);
        chk(stretch_enable, 1);
        wr(5'h04, 8'h2e);
        @(negedge clk);
        chk(scl_stretch, 1);
        wr(5'h04, 8'h2b);
        @(negedge clk);
        chk(scl_stretch, 0);
        wr(5'h04, 8'h06);
        @(negedge clk);
        chk(pins_to_port, 0);
        rdchk(5'h00, 8'h00, 8'h18);
        $display("test slave done");
        wr(5'h08, 8'h00);
        wr(5'h04, 8'h28);
        wr(5'h10, 8'h02);
        period;
        chk(32'(n), 32'd6);
        chk(slave_address_out, 8'h02);
        wr(5'h08, 8'h01);
        @(negedge clk);
        chk(module_active, 1);
        chk(master_cmd, 5'h01);
        wr(5'h08, 8'h05);
        rdchk(5'h08, 8'h01, 8'hff);
        wr(5'h0c, 8'h66);
        chk(32'(loads), 32'd0);
        rdchk(5'h04, 8'ha8, 8'hff);
        ev(2'h3, 8'h00, 1'b0);
        rdchk(5'h08, 8'h00, 8'h1f);
        chk(module_active, 0);
        wr(5'h08, 8'h30);
        @(negedge clk);
        chk(ack_out_value, 1);
        chk(master_cmd, 5'h10);
        ev(2'h3, 8'h00, 1'b0);
        rdchk(5'h08, 8'h20, 8'hff);
        wr(5'h08, 8'h08);
        rdchk(5'h08, 8'h08, 8'hff);
        chk(module_active, 1);
        chk(master_cmd, 5'h08);
        ack_in <= 1'b1;
        ev(2'h2, 8'h00, 1'b0);
        rdchk(5'h08, 8'h48, 8'hff);
        ack_in <= 1'b0;
        ev(2'h3, 8'h00, 1'b0);
        wr(5'h04, 8'h28);
        idle <= 1'b0;
        wr(5'h0c, 8'h77);
        rdchk(5'h04, 8'ha8, 8'hff);
        idle <= 1'b1;
        wr(5'h04, 8'h28);
        wr(5'h0c, 8'h55);
        @(negedge clk);
        chk(32'(loads), 32'd1);
        chk(data_buffer_out, 8'h55);
        $display("test master done");
        end_sim;
    end
endmodule : tb_serial_port_regs
`default_nettype wire
